//--- logic/wdt_defs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog core.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_ADDR_W      5
`define WDT_OFS_MODE    5'h00
`define WDT_OFS_TC      5'h04
`define WDT_OFS_FEED    5'h08
`define WDT_OFS_RB      5'h0c
`define WDT_OFS_IST     5'h10
`define WDT_OFS_ICLR    5'h14
`define WDT_OFS_IEN     5'h18

`define WDT_MODE_EN     0
`define WDT_MODE_RST    1
`define WDT_MODE_TOF    2
`define WDT_MODE_INT    3

`define WDT_EV_EXPIRY   0
`define WDT_EV_FAULT    1

`define WDT_TC_MIN      24'h0000ff
`define WDT_TC_RESET    24'h0000ff
`define WDT_FEED_FIRST  8'haa
`define WDT_FEED_SECOND 8'h55

`define WDT_PRESC_LAST  2'h3
`define WDT_SYNC_LAST   2'h2

`endif

//--- logic/wdt_pkg.sv
// Types shared by the watchdog core and its bench.
package wdt_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } wdt_av_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } wdt_av_rsp_type;

  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_HALF = 2'b10
  } wdt_feed_type;

  typedef struct packed {
    logic         bus_wait;
    logic [31:0]  rdata;
    wdt_feed_type feed;
    logic         en;
    logic         rst_en;
    logic         tof;
    logic         intf;
    logic [23:0]  tc;
    logic         cfg_pend;
    logic [1:0]   cfg_cnt;
    logic         rl_pend;
    logic [1:0]   rl_cnt;
    logic         en_act;
    logic         rst_act;
    logic [23:0]  tc_act;
    logic         started;
    logic [1:0]   presc;
    logic [23:0]  cnt;
    logic [23:0]  snap;
    logic [23:0]  rb;
    logic         cc1;
    logic         cc2;
    logic         cc3;
    logic         chip_rst;
    logic [1:0]   ist;
    logic [1:0]   ien;
    logic         irq;
  } wdt_state_type;

endpackage

//--- logic/wdt_core.sv
// Watchdog timer core with an Avalon-MM register slave.
// Notes on behaviour
// - Count clock is divided by four; each prescaled tick decrements the 24-bit counter.
// - A time-out constant below 0xff is replaced by 0xff.
// - Software cannot clear the enable bit once set.
// - A bad or incomplete refresh sequence while running triggers the expiry response.
// - Expiry in reset mode sets a flag that stays until software or a power-on reset clears it.
// - Writing 0xaa then 0x55 to the refresh port starts and refreshes the watchdog.
// - Underflow in reset mode issues a chip reset pulse.
// - Bus clock serves registers; the count clock paces prescaling and counting.
// - Mode and constant writes reach the counting logic three count clock cycles later.
// - The count is captured on the count clock, then copied for bus readback.
// - Each completed refresh reloads the counter with the current constant.
// - Enable and reset-enable clear only on power-on reset, system reset or expiry.
// - Underflow in interrupt mode sets a read-only flag and the interrupt request.
// - After 0xaa while running, any mode, constant, refresh or readback access but writing 0x55 to refresh triggers expiry.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`include "wdt_defs.svh"

module wdt_core (
  input  wire logic                    mclk_in,
  input  wire logic                    reset_in,
  input  wire logic                    por_in,
  input  wire logic                    count_clock_in,
  input  wire wdt_pkg::wdt_av_req_type bus_in,
  output wdt_pkg::wdt_av_rsp_type      bus_out,
  output logic                         chip_reset_out,
  output logic                         expiry_irq_out,
  output logic                         irq_out
);
  import wdt_pkg::*;

  localparam wdt_state_type RST = '{
    bus_wait: 1'b1,
    rdata:    32'h0,
    feed:     FEED_IDLE,
    tc:       `WDT_TC_RESET,
    tc_act:   `WDT_TC_RESET,
    cnt:      `WDT_TC_RESET,
    snap:     `WDT_TC_RESET,
    rb:       `WDT_TC_RESET,
    default:  '0
  };

  wdt_state_type state_r;
  wdt_state_type state_nxt;

  logic        acc;
  logic        wr;
  logic [4:0]  addr;
  logic [31:0] wd;
  logic        wdt_hit;
  logic        feed_done;
  logic        fault;
  logic        tick;
  logic        cfg_apply;
  logic        rl_apply;
  logic        underflow;
  logic        expire;
  logic [23:0] tc_new;

  always_comb begin
    state_nxt = state_r;
    state_nxt.chip_rst = 1'b0;
    addr = {bus_in.address[4:2], 2'b00};
    wd = bus_in.writedata;
    wr = bus_in.write;
    // A request is answered one cycle after it is seen and committed at the
    // edge where waitrequest is low.
    acc = (bus_in.read | bus_in.write) & ~state_r.bus_wait;
    wdt_hit = (addr == `WDT_OFS_MODE) | (addr == `WDT_OFS_TC) |
              (addr == `WDT_OFS_FEED) | (addr == `WDT_OFS_RB);
    feed_done = 1'b0;
    fault = 1'b0;
    underflow = 1'b0;
    tc_new = (wd[23:0] < `WDT_TC_MIN) ? `WDT_TC_MIN : wd[23:0];

    // The count clock is a pin; only the second and third stages are looked at.
    state_nxt.cc1 = count_clock_in;
    state_nxt.cc2 = state_r.cc1;
    state_nxt.cc3 = state_r.cc2;
    tick = state_r.cc2 & ~state_r.cc3;

    // Updates wait for the third count clock edge.
    cfg_apply = state_r.cfg_pend & tick & (state_r.cfg_cnt == `WDT_SYNC_LAST);
    rl_apply = state_r.rl_pend & tick & (state_r.rl_cnt == `WDT_SYNC_LAST);
    if (state_r.cfg_pend & tick) begin
      state_nxt.cfg_cnt = state_r.cfg_cnt + 2'h1;
    end
    if (state_r.rl_pend & tick) begin
      state_nxt.rl_cnt = state_r.rl_cnt + 2'h1;
    end
    if (cfg_apply) begin
      state_nxt.cfg_pend = 1'b0;
      state_nxt.en_act = state_r.en;
      state_nxt.rst_act = state_r.rst_en;
      state_nxt.tc_act = state_r.tc;
    end

    if (rl_apply) begin
      state_nxt.rl_pend = 1'b0;
      state_nxt.cnt = cfg_apply ? state_r.tc : state_r.tc_act;
      state_nxt.presc = 2'h0;
      state_nxt.started = state_r.en;
    end else if (tick & state_r.started & state_r.en_act) begin
      state_nxt.presc = state_r.presc + 2'h1;
      if (state_r.presc == `WDT_PRESC_LAST) begin
        if (state_r.cnt == 24'h0) begin
          underflow = 1'b1;
        end else begin
          state_nxt.cnt = state_r.cnt - 24'h1;
        end
      end
    end
    if (tick) begin
      state_nxt.snap = state_r.cnt;
    end
    state_nxt.rb = state_r.snap;

    // Bus answer phase.
    if ((bus_in.read | bus_in.write) & state_r.bus_wait) begin
      state_nxt.bus_wait = 1'b0;
      case (addr)
        `WDT_OFS_MODE: begin
          state_nxt.rdata = {28'h0, state_r.intf, state_r.tof, state_r.rst_en, state_r.en};
        end
        `WDT_OFS_TC: begin
          state_nxt.rdata = {8'h0, state_r.tc};
        end
        `WDT_OFS_RB: begin
          state_nxt.rdata = {8'h0, state_r.rb};
        end
        `WDT_OFS_IST: begin
          state_nxt.rdata = {30'h0, state_r.ist};
        end
        `WDT_OFS_IEN: begin
          state_nxt.rdata = {30'h0, state_r.ien};
        end
        default: begin
          state_nxt.rdata = 32'h0;
        end
      endcase
    end

    // Commit phase.
    if (acc) begin
      state_nxt.bus_wait = 1'b1;
      if (wr) begin
        case (addr)
          `WDT_OFS_MODE: begin
            state_nxt.en = state_r.en | wd[`WDT_MODE_EN];
            state_nxt.rst_en = state_r.rst_en | wd[`WDT_MODE_RST];
            if (!wd[`WDT_MODE_TOF]) begin
              state_nxt.tof = 1'b0;
            end
            state_nxt.cfg_pend = 1'b1;
            state_nxt.cfg_cnt = 2'h0;
          end
          `WDT_OFS_TC: begin
            state_nxt.tc = tc_new;
            state_nxt.cfg_pend = 1'b1;
            state_nxt.cfg_cnt = 2'h0;
          end
          `WDT_OFS_ICLR: begin
            state_nxt.ist = state_r.ist & ~wd[1:0];
          end
          `WDT_OFS_IEN: begin
            state_nxt.ien = wd[1:0];
          end
          default: begin
          end
        endcase
      end
      case (state_r.feed)
        FEED_IDLE: begin
          if (wr & (addr == `WDT_OFS_FEED) & (wd[7:0] == `WDT_FEED_FIRST)) begin
            state_nxt.feed = FEED_HALF;
          end
        end
        FEED_HALF: begin
          if (wdt_hit) begin
            state_nxt.feed = FEED_IDLE;
            if (wr & (addr == `WDT_OFS_FEED) & (wd[7:0] == `WDT_FEED_SECOND)) begin
              feed_done = 1'b1;
            end else begin
              fault = state_r.started;
            end
          end
        end
        default: begin
          state_nxt.feed = FEED_IDLE;
        end
      endcase
    end
    if (feed_done) begin
      state_nxt.rl_pend = 1'b1;
      state_nxt.rl_cnt = 2'h0;
    end

    // Expiry response; placed last so a set beats a same-cycle clear.
    expire = underflow | fault;
    if (expire) begin
      state_nxt.en = 1'b0;
      state_nxt.rst_en = 1'b0;
      state_nxt.en_act = 1'b0;
      state_nxt.rst_act = 1'b0;
      state_nxt.started = 1'b0;
      state_nxt.cfg_pend = 1'b0;
      state_nxt.rl_pend = 1'b0;
      state_nxt.feed = FEED_IDLE;
      if (state_r.rst_act) begin
        state_nxt.chip_rst = 1'b1;
        state_nxt.tof = 1'b1;
      end else begin
        state_nxt.intf = 1'b1;
      end
    end
    state_nxt.ist = state_nxt.ist | {fault, underflow};
    state_nxt.irq = |(state_nxt.ist & state_nxt.ien);
  end

  always_ff @(posedge mclk_in) begin
    if (por_in) begin
      state_r <= RST;
    end else if (reset_in) begin
      // The expiry flag survives a system reset so software can see its cause.
      state_r <= RST;
      state_r.tof <= state_r.tof;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus_out.readdata = state_r.rdata;
  assign bus_out.waitrequest = state_r.bus_wait;
  assign chip_reset_out = state_r.chip_rst;
  assign expiry_irq_out = state_r.intf;
  assign irq_out = state_r.irq;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in | por_in);

  AST_DECREMENT: assert property (
    tick && state_r.started && state_r.en_act && state_r.presc == 2'h3 &&
    state_r.cnt != 24'h0 && !rl_apply |=> state_r.cnt == $past(state_r.cnt) - 24'h1)
    else $error("counter did not step down on the fourth tick");

  AST_HOLD: assert property (
    tick && state_r.presc != 2'h3 && !rl_apply |=> state_r.cnt == $past(state_r.cnt))
    else $error("counter moved between prescaled ticks");

  AST_CLAMP: assert property (state_r.tc >= 24'hff)
    else $error("time-out constant below minimum");

  AST_LOCK: assert property (state_r.en && !expire |=> state_r.en)
    else $error("enable cleared without expiry");

  AST_FAULT: assert property (
    fault |=> (state_r.chip_rst || state_r.intf) && !state_r.started)
    else $error("feed fault gave no response");

  AST_TOF: assert property (
    state_r.tof && !(acc && wr && addr == 5'h00 && !wd[2]) |=> state_r.tof)
    else $error("expiry flag lost without a software clear");

  AST_FEED: assert property (
    feed_done && !expire |=> state_r.rl_pend && state_r.rl_cnt == 2'h0 &&
    state_r.feed == FEED_IDLE)
    else $error("completed refresh not queued");

  AST_RESETMODE: assert property (
    expire && state_r.rst_act |=> state_r.chip_rst && state_r.tof ##1 !state_r.chip_rst)
    else $error("reset mode expiry did not pulse chip reset");

  AST_CFGLAT: assert property (
    cfg_apply && !expire &&
    !(acc && wr && (addr == `WDT_OFS_MODE || addr == `WDT_OFS_TC)) |=>
    state_r.tc_act == $past(state_r.tc) && !state_r.cfg_pend)
    else $error("configuration not applied on the third tick");

  AST_SNAP: assert property (tick |=> state_r.snap == $past(state_r.cnt) ##1
    state_r.rb == $past(state_r.snap))
    else $error("readback capture out of step");

  AST_RELOAD: assert property (
    rl_apply && !cfg_apply && !expire |=> state_r.cnt == $past(state_r.tc_act))
    else $error("refresh did not reload the counter");

  AST_CLEAR: assert property (expire |=> !state_r.en && !state_r.rst_en)
    else $error("expiry left the watchdog enabled");

  AST_INTMODE: assert property (
    expire && !state_r.rst_act |=> state_r.intf && expiry_irq_out && !state_r.chip_rst)
    else $error("interrupt mode expiry did not raise the flag");

  AST_RLLAT: assert property (
    state_r.rl_pend && !tick && !expire && !feed_done |=> state_r.rl_pend &&
    state_r.rl_cnt == $past(state_r.rl_cnt))
    else $error("reload advanced without a count clock edge");

endmodule // wdt_core

//--- test/wdt_cclk_src.sv
// Count clock source that stands in for the watchdog clock generator.
`timescale 1ns/1ns
module wdt_cclk_src #(
  parameter int HALF = 4
) (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  output logic      count_clock_out
);
  int n;

  // Each phase spans several bus clocks so the core's synchroniser sees every edge.
  always @(posedge mclk_in) begin
    if (reset_in) begin
      n <= 0;
      count_clock_out <= 1'b0;
    end else if (n == HALF - 1) begin
      n <= 0;
      count_clock_out <= ~count_clock_out;
    end else begin
      n <= n + 1;
    end
  end
endmodule // wdt_cclk_src

//--- test/wdt_core_tb.sv
// Self-checking bench for the watchdog core.
`timescale 1ns/1ns
`include "wdt_defs.svh"
module wdt_core_tb;
  import wdt_pkg::*;
  logic           mclk_in = 1'b0;
  logic           reset_in = 1'b1;
  logic           por_in = 1'b1;
  logic           cclk;
  wdt_av_req_type bus_r = '0;
  wdt_av_rsp_type bus_o;
  logic           chip_rst;
  logic           exp_irq;
  logic           irq;
  int             err_total = 0;
  int             checks_done = 0;
  int             rst_seen = 0;
  logic [31:0]    q;

  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (chip_rst === 1'b1) rst_seen <= rst_seen + 1;

  wdt_cclk_src wdt_cclk_src_i (.mclk_in(mclk_in), .reset_in(por_in), .count_clock_out(cclk));

  wdt_core wdt_core_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .por_in(por_in), .count_clock_in(cclk),
    .bus_in(bus_r), .bus_out(bus_o), .chip_reset_out(chip_rst),
    .expiry_irq_out(exp_irq), .irq_out(irq)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; read data lands in q at the edge where waitrequest is sampled low.
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    bus_r.read <= ~w;
    bus_r.write <= w;
    bus_r.address <= a;
    bus_r.writedata <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (bus_o.waitrequest !== 1'b0 && n < 50);
    q = bus_o.readdata;
    bus_r.read <= 1'b0;
    bus_r.write <= 1'b0;
    @(posedge mclk_in);
    if (n >= 50) begin
      err_total++;
      results();
    end
  endtask

  task automatic feed();
    acc(1'b1, `WDT_OFS_FEED, 32'haa);
    acc(1'b1, `WDT_OFS_FEED, 32'h55);
  endtask

  task automatic rst_pulse();
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic t_reset();
    acc(1'b0, `WDT_OFS_TC, 32'h0);
    chk(q, 32'hff);
    acc(1'b0, `WDT_OFS_RB, 32'h0);
    chk(q, 32'hff);
    acc(1'b0, `WDT_OFS_MODE, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, `WDT_OFS_TC, 32'hfe);
    acc(1'b0, `WDT_OFS_TC, 32'h0);
    chk(q, 32'hff);
    acc(1'b1, 5'h1c, 32'h1234);
    acc(1'b0, 5'h1c, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_irq();
    int n;
    acc(1'b1, `WDT_OFS_TC, 32'h0);
    acc(1'b1, `WDT_OFS_MODE, 32'h1);
    feed();
    acc(1'b1, `WDT_OFS_MODE, 32'h0);
    acc(1'b0, `WDT_OFS_MODE, 32'h0);
    chk(q, 32'h1);
    repeat (3000) @(posedge mclk_in);
    acc(1'b0, `WDT_OFS_RB, 32'h0);
    chk({31'h0, q < 32'hff && q > 32'h0}, 32'h1);
    chk({31'h0, exp_irq}, 32'h0);
    feed();
    n = 0;
    while (exp_irq !== 1'b1 && n < 12000) begin
      @(posedge mclk_in);
      n++;
    end
    // 1027 ticks of 8 clocks after the refresh, plus synchroniser delay.
    chk({31'h0, n >= 8170 && n <= 8260}, 32'h1);
    if (n >= 12000) begin
      results();
    end
    acc(1'b0, `WDT_OFS_MODE, 32'h0);
    chk(q, 32'h8);
    acc(1'b0, `WDT_OFS_IST, 32'h0);
    chk(q, 32'h1);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `WDT_OFS_IEN, 32'h1);
    repeat (2) @(posedge mclk_in);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `WDT_OFS_ICLR, 32'h1);
    repeat (2) @(posedge mclk_in);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, exp_irq}, 32'h1);
    rst_pulse();
    chk({31'h0, exp_irq}, 32'h0);
    $display("test interrupt mode done");
  endtask

  task automatic t_fault();
    int base;
    acc(1'b1, `WDT_OFS_IEN, 32'h2);
    acc(1'b1, `WDT_OFS_TC, 32'h300);
    acc(1'b1, `WDT_OFS_MODE, 32'h3);
    feed();
    // Faults count only once the mode and the reload have crossed to the count logic.
    repeat (64) @(posedge mclk_in);
    base = rst_seen;
    acc(1'b1, `WDT_OFS_FEED, 32'haa);
    acc(1'b0, `WDT_OFS_TC, 32'h0);
    repeat (2) @(posedge mclk_in);
    chk(rst_seen - base, 32'h1);
    chk({31'h0, irq}, 32'h1);
    acc(1'b0, `WDT_OFS_MODE, 32'h0);
    chk(q, 32'h4);
    rst_pulse();
    acc(1'b0, `WDT_OFS_MODE, 32'h0);
    chk(q, 32'h4);
    acc(1'b1, `WDT_OFS_MODE, 32'h0);
    acc(1'b0, `WDT_OFS_MODE, 32'h0);
    chk(q, 32'h0);
    $display("test feed fault done");
  endtask

  initial begin
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    por_in <= 1'b0;
    @(posedge mclk_in);
    t_reset();
    t_irq();
    t_fault();
    results();
  end
endmodule // wdt_core_tb
